// ===== logic/dhsm_pkg.sv
`default_nettype none
package dhsm_pkg;
    // operation select codes
    localparam logic [2:0] OP_HALVING_SUB_ADD_EXCHANGE = 3'h0;
    localparam logic [2:0] OP_HALVING_SUB_PAIR         = 3'h1;
    localparam logic [2:0] OP_HALVING_SUB_QUAD         = 3'h2;
    localparam logic [2:0] OP_HALF_MUL_ACC             = 3'h3;
    localparam logic [2:0] OP_DUAL_MUL_ACC             = 3'h4;
    localparam logic [3:0] ACC_FIELD_NONE              = 4'hF;
    localparam logic [3:0] REG_STACK_PTR               = 4'hD;
    localparam logic [3:0] REG_PROG_CNT                = 4'hF;
    localparam logic [31:0] DEST_RESET                 = 32'h0000_0000;
    localparam logic        STICKY_RESET               = 1'h0;
    localparam int          HALF_W                     = 16;
    localparam int          BYTE_W                     = 8;

    typedef struct packed {
        logic [31:0] dest_reg;
        logic        dest_write;
        logic        sticky_overflow_bit;
        logic        unpredictable;
    } dhsm_state_type;
endpackage
`default_nettype wire

// ===== logic/dhsm_datapath.sv
// Overview of operation
// - halving_sub_add_exchange writes bits 16:1 of low(first)+high(second) low and high(first)-low(second) high.
// - halving_sub_pair writes bits 16:1 of each signed halfword difference into the matching half.
// - halving_sub_quad writes bits 8:1 of each of four signed 9-bit byte differences into its lane.
// - a halfword multiply-accumulate with accumulate field 1111 runs as the non-accumulating multiply.
// - a dual multiply-accumulate with accumulate field 1111 runs as dual multiply-add without accumulate.
// - register 13 or 15 as destination or source, or 13 as accumulate, makes a multiply-accumulate result unpredictable.
// - each top-pick bit takes bits 31:16 of its source when set and bits 15:0 when clear.
// - the signed 32-bit halfword product plus the accumulate operand gives the low 32 bits of the result.
// - signed overflow of the halfword accumulation sets the sticky overflow bit, never clears it.
// - the 16x16 products cannot overflow, so only the accumulation is checked.
// - the dual form adds two signed 16x16 products to the 32-bit accumulate operand.
// - with second_top_pick set the second operand halves are swapped for the dual form.
// - signed overflow of the dual accumulation sets the sticky overflow bit.
`default_nettype none
module dhsm_datapath
    import dhsm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        op_valid,
    input  wire logic        cond_passed,
    input  wire logic [2:0]  op_select,
    input  wire logic [31:0] first_src_reg,
    input  wire logic [31:0] second_src_reg,
    input  wire logic [31:0] acc_src_reg,
    input  wire logic [3:0]  acc_field,
    input  wire logic [3:0]  dest_field,
    input  wire logic [3:0]  first_field,
    input  wire logic [3:0]  second_field,
    input  wire logic        first_top_pick,
    input  wire logic        second_top_pick,
    input  wire logic        sticky_clear,
    output logic [31:0]      dest_reg,
    output logic             dest_write,
    output logic             sticky_overflow_bit,
    output logic             unpredictable
);
    dhsm_state_type state;
    dhsm_state_type next_state;

    // halving results: one spare top bit so the halved value keeps the carry
    logic signed [16:0] hx_sum;
    logic signed [16:0] hx_diff;
    wire signed [16:0]  pair_diff [2];
    wire signed [8:0]   quad_diff [4];
    logic [31:0]        hx_result;
    wire [31:0]         pair_result;
    wire [31:0]         quad_result;

    // multiplier operands, products and the wide accumulation
    logic signed [15:0] op_a;
    logic signed [15:0] op_b;
    logic signed [31:0] half_prod;
    logic signed [31:0] dual_prod_lo;
    logic signed [31:0] dual_prod_hi;
    logic [31:0]        second_swapped;
    logic signed [33:0] prod_sum;
    logic signed [33:0] acc_term;
    logic signed [33:0] wide_sum;
    logic               acc_overflow;
    logic               use_acc;
    logic               is_mac;

    // register numbers that make a multiply-accumulate unpredictable
    logic               dest_bad;
    logic               first_bad;
    logic               second_bad;
    logic               acc_bad;
    logic               reg_hazard;

    // exchange form: low result from the sum, high result from the difference
    always_comb
    begin
        hx_sum = 17'(signed'(first_src_reg[15:0])) + 17'(signed'(second_src_reg[31:16]));
        hx_diff = 17'(signed'(first_src_reg[31:16])) - 17'(signed'(second_src_reg[15:0]));
        hx_result = {hx_diff[16:1], hx_sum[16:1]};
    end

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_pair
            assign pair_diff[i] = 17'(signed'(first_src_reg[i*HALF_W +: HALF_W]))
                                - 17'(signed'(second_src_reg[i*HALF_W +: HALF_W]));
            assign pair_result[i*HALF_W +: HALF_W] = pair_diff[i][16:1];
        end
        for (genvar j = 0; j < 4; j++)
        begin : g_quad
            assign quad_diff[j] = 9'(signed'(first_src_reg[j*BYTE_W +: BYTE_W]))
                                - 9'(signed'(second_src_reg[j*BYTE_W +: BYTE_W]));
            assign quad_result[j*BYTE_W +: BYTE_W] = quad_diff[j][8:1];
        end
    endgenerate

    // multiply operands; 16x16 signed products always fit in 32 bits
    always_comb
    begin
        op_a = first_top_pick ? first_src_reg[31:16] : first_src_reg[15:0];
        op_b = second_top_pick ? second_src_reg[31:16] : second_src_reg[15:0];
        half_prod = 32'(op_a) * 32'(op_b);
        second_swapped = second_top_pick ? {second_src_reg[15:0], second_src_reg[31:16]}
                                         : second_src_reg;
        dual_prod_lo = 32'(signed'(first_src_reg[15:0])) * 32'(signed'(second_swapped[15:0]));
        dual_prod_hi = 32'(signed'(first_src_reg[31:16])) * 32'(signed'(second_swapped[31:16]));
    end

    // accumulation, wide enough that the sum itself never wraps
    always_comb
    begin
        use_acc = (acc_field != ACC_FIELD_NONE);
        if (op_select == OP_DUAL_MUL_ACC)
        begin
            prod_sum = 34'(dual_prod_lo) + 34'(dual_prod_hi);
        end
        else
        begin
            prod_sum = 34'(half_prod);
        end
        if (use_acc)
        begin
            acc_term = 34'(signed'(acc_src_reg));
        end
        else
        begin
            acc_term = 34'h0;
        end
        wide_sum = prod_sum + acc_term;
        acc_overflow = (wide_sum != 34'(signed'(wide_sum[31:0])));
    end

    always_comb
    begin
        is_mac = (op_select == OP_HALF_MUL_ACC) || (op_select == OP_DUAL_MUL_ACC);
        dest_bad = (dest_field == REG_STACK_PTR) || (dest_field == REG_PROG_CNT);
        first_bad = (first_field == REG_STACK_PTR) || (first_field == REG_PROG_CNT);
        second_bad = (second_field == REG_STACK_PTR) || (second_field == REG_PROG_CNT);
        acc_bad = (acc_field == REG_STACK_PTR);
        reg_hazard = is_mac && (dest_bad || first_bad || second_bad || acc_bad);
    end

    always_comb
    begin
        next_state = state;
        next_state.dest_write = 1'b0;
        // a clear and an overflow in one cycle: the overflow wins
        if (sticky_clear)
        begin
            next_state.sticky_overflow_bit = 1'b0;
        end
        if (op_valid && cond_passed)
        begin
            case (op_select)
                OP_HALVING_SUB_ADD_EXCHANGE:
                begin
                    next_state.dest_write = 1'b1;
                    next_state.dest_reg = hx_result;
                    next_state.unpredictable = 1'b0;
                end
                OP_HALVING_SUB_PAIR:
                begin
                    next_state.dest_write = 1'b1;
                    next_state.dest_reg = pair_result;
                    next_state.unpredictable = 1'b0;
                end
                OP_HALVING_SUB_QUAD:
                begin
                    next_state.dest_write = 1'b1;
                    next_state.dest_reg = quad_result;
                    next_state.unpredictable = 1'b0;
                end
                OP_HALF_MUL_ACC, OP_DUAL_MUL_ACC:
                begin
                    next_state.dest_write = 1'b1;
                    next_state.dest_reg = wide_sum[31:0];
                    next_state.unpredictable = reg_hazard;
                    if (acc_overflow)
                    begin
                        next_state.sticky_overflow_bit = 1'b1;
                    end
                end
                default:
                begin
                    next_state.dest_write = 1'b0;
                end
            endcase
        end
    end

    // all state holds while clk_en is low
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state.dest_reg <= DEST_RESET;
            state.dest_write <= 1'b0;
            state.sticky_overflow_bit <= STICKY_RESET;
            state.unpredictable <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
        end
    end

    // outputs come straight from the state register
    assign dest_reg = state.dest_reg;
    assign dest_write = state.dest_write;
    assign sticky_overflow_bit = state.sticky_overflow_bit;
    assign unpredictable = state.unpredictable;
endmodule
`default_nettype wire

// ===== testbench/dhsm_datapath_assertions.sv
`default_nettype none
module dhsm_datapath_assertions
    import dhsm_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        op_valid,
    input wire logic        cond_passed,
    input wire logic        first_top_pick,
    input wire logic        second_top_pick,
    input wire logic        sticky_clear,
    input wire logic        dest_write,
    input wire logic        sticky_overflow_bit,
    input wire logic        unpredictable,
    input wire logic [2:0]  op_select,
    input wire logic [3:0]  acc_field,
    input wire logic [3:0]  dest_field,
    input wire logic [3:0]  first_field,
    input wire logic [3:0]  second_field,
    input wire logic [31:0] first_src_reg,
    input wire logic [31:0] second_src_reg,
    input wire logic [31:0] acc_src_reg,
    input wire logic [31:0] dest_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [31:0] n = first_src_reg, m = second_src_reg, o = second_top_pick ? {m[15:0], m[31:16]} : m;
    wire signed [15:0] nl = n[15:0], nh = n[31:16], ml = m[15:0], mh = m[31:16], ol = o[15:0], oh = o[31:16];
    wire signed [15:0] h1 = first_top_pick ? nh : nl, h2 = second_top_pick ? mh : ml;
    wire signed [16:0] s = nl + mh, d = nh - ml, p0 = nl - ml, p1 = nh - mh;
    wire signed [8:0] q0 = $signed(n[7:0]) - $signed(m[7:0]), q1 = $signed(n[15:8]) - $signed(m[15:8]);
    wire signed [8:0] q2 = $signed(n[23:16]) - $signed(m[23:16]), q3 = $signed(n[31:24]) - $signed(m[31:24]);
    wire signed [33:0] ac = acc_field == ACC_FIELD_NONE ? 34'sh0 : $signed(acc_src_reg);
    wire signed [33:0] r = op_select == 3'h3 ? h1 * h2 + ac : nl * ol + nh * oh + ac;
    wire [31:0] ex = {d[16:1], s[16:1]}, ep = {p1[16:1], p0[16:1]}, em = r[31:0];
    wire [31:0] eq = {q3[8:1], q2[8:1], q1[8:1], q0[8:1]};
    wire take = clk_en && op_valid && cond_passed;
    wire mac = take && (op_select == 3'h3 || op_select == 3'h4);
    wire ovf = r[33:31] != 3'h0 && r[33:31] != 3'h7;
    wire hazard = dest_field == REG_STACK_PTR || dest_field == REG_PROG_CNT || first_field == REG_STACK_PTR
        || first_field == REG_PROG_CNT || second_field == REG_STACK_PTR || second_field == REG_PROG_CNT
        || acc_field == REG_STACK_PTR;
    property p_take; take && op_select <= 3'h4 |=> dest_write; endproperty
    a_take: assert property (p_take) else $error("no write");
    property p_refuse; clk_en && !take |=> !dest_write && $stable(dest_reg); endproperty
    a_refuse: assert property (p_refuse) else $error("refused op wrote");
    property p_xch; take && op_select == 3'h0 |=> dest_reg == $past(ex); endproperty
    a_xch: assert property (p_xch) else $error("exchange result");
    property p_pair; take && op_select == 3'h1 |=> dest_reg == $past(ep); endproperty
    a_pair: assert property (p_pair) else $error("pair result");
    property p_quad; take && op_select == 3'h2 |=> dest_reg == $past(eq); endproperty
    a_quad: assert property (p_quad) else $error("quad result");
    property p_mac; mac |=> dest_reg == $past(em); endproperty
    a_mac: assert property (p_mac) else $error("mac result");
    property p_ovf; mac && ovf |=> sticky_overflow_bit; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");
    property p_keep; sticky_overflow_bit && !sticky_clear |=> sticky_overflow_bit; endproperty
    a_keep: assert property (p_keep) else $error("sticky lost");
    property p_unp; mac && hazard |=> unpredictable; endproperty
    a_unp: assert property (p_unp) else $error("unpredictable missed");
    property p_safe; mac && !hazard |=> !unpredictable; endproperty
    a_safe: assert property (p_safe) else $error("unpredictable raised without hazard");
    c_ovf: cover property (mac && ovf);
    c_quad: cover property (take && op_select == 3'h2);
    c_ref: cover property (op_valid && !cond_passed);
endmodule
bind dhsm_datapath dhsm_datapath_assertions u_chk (.*);
`default_nettype wire

// ===== testbench/dhsm_regfile_model.sv
`default_nettype none
module dhsm_regfile_model
(
    input wire logic        ref_clk,
    input wire logic        dest_write,
    output var int          wb_count
);
    timeunit 1ns; timeprecision 1ns;
    // counts results handed back for write-back
    initial wb_count = 0;
    always @(posedge ref_clk) if (dest_write) wb_count <= wb_count + 1;
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns; timeprecision 1ns;
    import dhsm_pkg::*;
    logic ref_clk = 0, rst_n = 0, op_valid = 0, cond_passed = 0, p1 = 0, p2 = 0, sclr = 0, dw, sticky, unp;
    logic ce = 1;
    logic [2:0] sel = 0;
    logic [3:0] accf = 0, dfld = 0, ffld = 0, sfld = 0;
    logic [31:0] a = 0, b = 0, c = 0, dest_reg;
    int errors = 0, n_tests = 0, wbs;
    always #5 ref_clk = ~ref_clk;
    dhsm_datapath u_dut (.ref_clk, .rst_n, .clk_en(ce), .op_valid, .cond_passed, .op_select(sel),
        .first_src_reg(a), .second_src_reg(b), .acc_src_reg(c), .acc_field(accf), .dest_field(dfld),
        .first_field(ffld), .second_field(sfld), .first_top_pick(p1), .second_top_pick(p2),
        .sticky_clear(sclr), .dest_reg, .dest_write(dw), .sticky_overflow_bit(sticky), .unpredictable(unp));
    dhsm_regfile_model u_rf (.ref_clk, .dest_write(dw), .wb_count(wbs));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic [2:0] s, input logic [31:0] x, y, z, input logic [3:0] f,
                      input logic t1, t2, cp, input logic [31:0] e, input logic [2:0] fl);
        @(posedge ref_clk);
        #1 {sel, a, b, c, accf, p1, p2, cond_passed, op_valid} = {s, x, y, z, f, t1, t2, cp, 1'h1};
        @(posedge ref_clk);
        #1 op_valid = 0;
        chk(dest_reg, e);
        chk({29'h0, dw, sticky, unp}, {29'h0, fl});
    endtask
    task automatic t_halving();
        op(3'h0, 32'h8000_0010, 32'h0006_0002, 32'h0, 4'h1, 1'h0, 1'h0, 1'h1, 32'hBFFF_000B, 3'h4);
        op(3'h1, 32'h8000_0003, 32'h7FFF_0005, 32'h0, 4'h1, 1'h0, 1'h0, 1'h1, 32'h8000_FFFF, 3'h4);
        op(3'h2, 32'h807F_0500, 32'h7F80_0301, 32'h0, 4'h1, 1'h0, 1'h0, 1'h1, 32'h807F_01FF, 3'h4);
    endtask
    task automatic t_half();
        logic [31:0] e [4] = '{32'h72, 32'h6E, 32'h79, 32'h73};
        for (int i = 0; i < 4; i++)
            op(3'h3, 32'h0003_0002, 32'h0005_0007, 32'h64, 4'h1, i[1], i[0], 1'h1, e[i], 3'h4);
        op(3'h3, 32'h0003_0002, 32'h0005_0007, 32'h64, ACC_FIELD_NONE, 1'h1, 1'h1, 1'h1, 32'hF, 3'h4);
        op(3'h3, 32'h8000, 32'h8000, 32'h7FFF_FFFF, 4'h1, 1'h0, 1'h0, 1'h1, 32'hBFFF_FFFF, 3'h6);
    endtask
    task automatic t_refuse();
        op(3'h4, 32'h8000_8000, 32'h8000_8000, 32'h0, 4'h1, 1'h0, 1'h0, 1'h0, 32'hBFFF_FFFF, 3'h2);
        op(3'h5, 32'h1, 32'h1, 32'h0, 4'h1, 1'h0, 1'h0, 1'h1, 32'hBFFF_FFFF, 3'h2);
        ce = 0;
        op(3'h0, 32'h1, 32'h1, 32'h0, 4'h1, 1'h0, 1'h0, 1'h1, 32'hBFFF_FFFF, 3'h2);
        ce = 1;
        @(posedge ref_clk);
        #1 sclr = 1;
        @(posedge ref_clk);
        #1 sclr = 0;
        chk({31'h0, sticky}, 32'h0);
    endtask
    task automatic t_dual();
        op(3'h4, 32'h0003_0002, 32'h0005_0007, 32'h64, 4'h1, 1'h0, 1'h0, 1'h1, 32'h81, 3'h4);
        op(3'h4, 32'h0003_0002, 32'h0005_0007, 32'h64, 4'h1, 1'h0, 1'h1, 1'h1, 32'h83, 3'h4);
        op(3'h4, 32'h0003_0002, 32'h0005_0007, 32'h64, ACC_FIELD_NONE, 1'h0, 1'h0, 1'h1, 32'h1D, 3'h4);
        op(3'h4, 32'h8000_8000, 32'h8000_8000, 32'h0, ACC_FIELD_NONE, 1'h0, 1'h0, 1'h1, 32'h8000_0000, 3'h6);
        dfld = REG_STACK_PTR;
        op(3'h3, 32'h0003_0002, 32'h0005_0007, 32'h64, 4'h1, 1'h0, 1'h0, 1'h1, 32'h72, 3'h7);
        dfld = 4'h0;
        ffld = REG_PROG_CNT;
        op(3'h3, 32'h0003_0002, 32'h0005_0007, 32'h64, 4'h1, 1'h0, 1'h0, 1'h1, 32'h72, 3'h7);
        ffld = 4'h0;
        sfld = REG_STACK_PTR;
        op(3'h3, 32'h0003_0002, 32'h0005_0007, 32'h64, 4'h1, 1'h0, 1'h0, 1'h1, 32'h72, 3'h7);
    endtask
    task automatic stop_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1;
        t_halving();
        t_half();
        t_refuse();
        t_dual();
        @(posedge ref_clk);
        #1 chk(32'(wbs), 32'h10);
        stop_test();
    end
endmodule
`default_nettype wire
